// ===== rtl/jepc_params.svh
// Constants for the environment and power parameter group codec
`ifndef JEPC_PARAMS_SVH
`define JEPC_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and repetition rates
// ----------------------------------------------------------------
`define JEPC_CLK_HZ 125000000
`define JEPC_MS_PER_S 1000
`define JEPC_AMB_RATE_MS 1000
`define JEPC_INEX_RATE_MS 500
`define JEPC_PWR_RATE_MS 1000

// ----------------------------------------------------------------
// Identifier fields
// ----------------------------------------------------------------
`define JEPC_ID_W 29
`define JEPC_PL_W 64
`define JEPC_DATA_PAGE 1'h0
`define JEPC_EXT_PAGE 1'h0
`define JEPC_PDU_FMT 8'hfe
`define JEPC_PS_AMB 8'hf5
`define JEPC_PS_INEX 8'hf6
`define JEPC_PS_PWR 8'hf7
`define JEPC_DEF_PRIO 3'h6
`define JEPC_ID_SA_LSB 0
`define JEPC_ID_PS_LSB 8
`define JEPC_ID_PF_LSB 16
`define JEPC_ID_DP_BIT 24
`define JEPC_ID_EDP_BIT 25

// ----------------------------------------------------------------
// Payload byte positions, byte 1 in the low bits
// ----------------------------------------------------------------
`define JEPC_BYTE1 0
`define JEPC_BYTE2 8
`define JEPC_BYTE3 16
`define JEPC_BYTE4 24
`define JEPC_BYTE5 32
`define JEPC_BYTE6 40
`define JEPC_BYTE7 48
`define JEPC_BYTE8 56

// ----------------------------------------------------------------
// Range limits in counts, and buffering
// ----------------------------------------------------------------
`define JEPC_MAX_BYTE 8'hfa
`define JEPC_MAX_TEMP16 16'hfb00
`define JEPC_MAX_VOLT16 16'hfaff
`define JEPC_FIFO_DEPTH 4

`endif

// ===== rtl/jepc_pkg.sv
// Types shared by the codec modules
`default_nettype none
package jepc_pkg;
    typedef enum logic [1:0] {
        JEPC_GRP_NONE,
        JEPC_GRP_AMB,
        JEPC_GRP_INEX,
        JEPC_GRP_PWR
    } jepc_grp_t;
    typedef logic [28:0] jepc_id_t;
    typedef logic [63:0] jepc_payload_t;
endpackage : jepc_pkg
`default_nettype wire

// ===== rtl/jepc_frame_if.sv
// Valid/ready carrier for packed frames between codec modules
`default_nettype none
interface jepc_frame_if #(parameter int W = 93);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : jepc_frame_if
`default_nettype wire

// ===== rtl/jepc_fifo.sv
// Small frame FIFO with valid/ready on both sides
`default_nettype none
module jepc_fifo #(
    parameter int W = 93,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_l,
    jepc_frame_if.snk wr,
    jepc_frame_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("jepc_fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;
    wire full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    wire empty = (wptr_q == rptr_q);
    wire do_wr = wr.valid && !full;
    wire do_rd = rd.ready && !empty;

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem_q[rptr_q[AW-1:0]];

    always_ff @(posedge sys_clk or negedge rst_l) begin
        if (!rst_l) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (do_wr) wptr_q <= wptr_q + 1'b1;
            if (do_rd) rptr_q <= rptr_q + 1'b1;
        end
    end

    // Storage has no reset; empty flag guards stale words
    always_ff @(posedge sys_clk) begin
        if (do_wr) mem_q[wptr_q[AW-1:0]] <= wr.data;
    end
endmodule : jepc_fifo
`default_nettype wire

// ===== rtl/jepc_period_timer.sv
// Free-running repetition timer, one pulse per period
`default_nettype none
module jepc_period_timer #(
    parameter int unsigned PERIOD = 1000
) (
    input wire logic sys_clk,
    input wire logic rst_l,
    output logic expire_q
);
    if (PERIOD < 2) begin : g_chk
        $error("jepc_period_timer period must be at least 2 cycles");
    end

    logic [31:0] cnt_q;
    wire wrap = (cnt_q == 32'(PERIOD - 1));

    always_ff @(posedge sys_clk or negedge rst_l) begin
        if (!rst_l) begin
            cnt_q <= '0;
            expire_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + 32'h1;
            expire_q <= wrap;
        end
    end
endmodule : jepc_period_timer
`default_nettype wire

// ===== rtl/jepc_host_codec.sv
// Packs and sends the three groups, and unpacks received ones
`include "jepc_params.svh"
`default_nettype none
module jepc_host_codec #(
    parameter int unsigned AMB_PERIOD_CYC = `JEPC_AMB_RATE_MS * (`JEPC_CLK_HZ / `JEPC_MS_PER_S),
    parameter int unsigned INEX_PERIOD_CYC = `JEPC_INEX_RATE_MS * (`JEPC_CLK_HZ / `JEPC_MS_PER_S),
    parameter int unsigned PWR_PERIOD_CYC = `JEPC_PWR_RATE_MS * (`JEPC_CLK_HZ / `JEPC_MS_PER_S),
    parameter int FIFO_DEPTH = `JEPC_FIFO_DEPTH,
    parameter logic [2:0] TX_PRIO = `JEPC_DEF_PRIO
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] src_addr,
    // Ambient conditions, raw counts
    input wire logic [7:0] baro_press,
    input wire logic [15:0] cab_temp,
    input wire logic [15:0] amb_temp,
    input wire logic [7:0] inlet_temp,
    input wire logic [15:0] road_temp,
    // Inlet/exhaust conditions, raw counts
    input wire logic [7:0] trap_press,
    input wire logic [7:0] boost_press,
    input wire logic [7:0] manifold_temp,
    input wire logic [7:0] inlet_press,
    input wire logic [7:0] filter_dp,
    input wire logic [15:0] exhaust_temp,
    input wire logic [7:0] coolant_dp,
    // Electrical power, raw counts
    input wire logic [7:0] batt_current,
    input wire logic [7:0] alt_current,
    input wire logic [15:0] alt_volt,
    input wire logic [15:0] elec_volt,
    input wire logic [15:0] sw_batt_volt,
    // Frame to the network
    output logic tx_valid_q,
    input wire logic tx_ready,
    output jepc_pkg::jepc_id_t tx_id_q,
    output jepc_pkg::jepc_payload_t tx_data_q,
    // Frame from the network
    input wire logic rx_valid,
    input wire jepc_pkg::jepc_id_t rx_id,
    input wire jepc_pkg::jepc_payload_t rx_data,
    output logic rx_hit_q,
    output jepc_pkg::jepc_grp_t rx_grp_q,
    output logic [2:0] rx_prio_q,
    output logic [7:0] rx_src_q,
    output logic [7:0] rx_baro_press_q,
    output logic [15:0] rx_cab_temp_q,
    output logic [15:0] rx_amb_temp_q,
    output logic [7:0] rx_inlet_temp_q,
    output logic [15:0] rx_road_temp_q,
    output logic [7:0] rx_trap_press_q,
    output logic [7:0] rx_boost_press_q,
    output logic [7:0] rx_manifold_temp_q,
    output logic [7:0] rx_inlet_press_q,
    output logic [7:0] rx_filter_dp_q,
    output logic [15:0] rx_exhaust_temp_q,
    output logic [7:0] rx_coolant_dp_q,
    output logic [7:0] rx_batt_current_q,
    output logic [7:0] rx_alt_current_q,
    output logic [15:0] rx_alt_volt_q,
    output logic [15:0] rx_elec_volt_q,
    output logic [15:0] rx_sw_batt_volt_q
);
    localparam int FW = `JEPC_ID_W + `JEPC_PL_W;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic jepc_pkg::jepc_id_t make_id(input logic [2:0] prio,
                                                   input logic [7:0] ps,
                                                   input logic [7:0] sa);
        make_id = {prio, `JEPC_EXT_PAGE, `JEPC_DATA_PAGE, `JEPC_PDU_FMT, ps, sa};
    endfunction : make_id

    // Out-of-range counts are clamped rather than sent as wrapped values
    function automatic logic [7:0] sat8(input logic [7:0] v);
        sat8 = (v > `JEPC_MAX_BYTE) ? `JEPC_MAX_BYTE : v;
    endfunction : sat8

    function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] lim);
        sat16 = (v > lim) ? lim : v;
    endfunction : sat16

    // Maps a received identifier onto a group, priority is not checked
    function automatic jepc_pkg::jepc_grp_t grp_of(input jepc_pkg::jepc_id_t id);
        logic base_ok;
        logic [7:0] ps;
        base_ok = (id[`JEPC_ID_EDP_BIT] == `JEPC_EXT_PAGE)
                  && (id[`JEPC_ID_DP_BIT] == `JEPC_DATA_PAGE)
                  && (id[`JEPC_ID_PF_LSB +: 8] == `JEPC_PDU_FMT);
        ps = id[`JEPC_ID_PS_LSB +: 8];
        if (!base_ok) grp_of = jepc_pkg::JEPC_GRP_NONE;
        else if (ps == `JEPC_PS_AMB) grp_of = jepc_pkg::JEPC_GRP_AMB;
        else if (ps == `JEPC_PS_INEX) grp_of = jepc_pkg::JEPC_GRP_INEX;
        else if (ps == `JEPC_PS_PWR) grp_of = jepc_pkg::JEPC_GRP_PWR;
        else grp_of = jepc_pkg::JEPC_GRP_NONE;
    endfunction : grp_of

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    wire rst_l = rst_sync_q[1];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rst_sync_q <= 2'h0;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // ----------------------------------------------------------------
    // Repetition timers
    // ----------------------------------------------------------------
    logic amb_exp;
    logic inex_exp;
    logic pwr_exp;

    jepc_period_timer #(.PERIOD(AMB_PERIOD_CYC)) u_amb_tmr (
        .sys_clk(sys_clk),
        .rst_l(rst_l),
        .expire_q(amb_exp)
    );

    jepc_period_timer #(.PERIOD(INEX_PERIOD_CYC)) u_inex_tmr (
        .sys_clk(sys_clk),
        .rst_l(rst_l),
        .expire_q(inex_exp)
    );

    jepc_period_timer #(.PERIOD(PWR_PERIOD_CYC)) u_pwr_tmr (
        .sys_clk(sys_clk),
        .rst_l(rst_l),
        .expire_q(pwr_exp)
    );

    // ----------------------------------------------------------------
    // Payload packing, byte 1 in the low bits
    // ----------------------------------------------------------------
    wire jepc_pkg::jepc_payload_t amb_pl = {
        sat16(road_temp, `JEPC_MAX_TEMP16),
        sat8(inlet_temp),
        sat16(amb_temp, `JEPC_MAX_TEMP16),
        sat16(cab_temp, `JEPC_MAX_TEMP16),
        sat8(baro_press)
    };
    wire jepc_pkg::jepc_payload_t inex_pl = {
        sat8(coolant_dp),
        sat16(exhaust_temp, `JEPC_MAX_TEMP16),
        sat8(filter_dp),
        sat8(inlet_press),
        sat8(manifold_temp),
        sat8(boost_press),
        sat8(trap_press)
    };
    wire jepc_pkg::jepc_payload_t pwr_pl = {
        sat16(sw_batt_volt, `JEPC_MAX_VOLT16),
        sat16(elec_volt, `JEPC_MAX_VOLT16),
        sat16(alt_volt, `JEPC_MAX_VOLT16),
        sat8(alt_current),
        sat8(batt_current)
    };

    // ----------------------------------------------------------------
    // Scheduler: one pending flag per group, shortest period first
    // ----------------------------------------------------------------
    logic [2:0] due_q;
    jepc_frame_if #(.W(FW)) q_in ();
    jepc_frame_if #(.W(FW)) q_out ();

    wire [2:0] expire = {pwr_exp, inex_exp, amb_exp};
    wire sel_inex = due_q[1];
    wire sel_amb = due_q[0] && !due_q[1];
    wire sel_pwr = due_q[2] && !due_q[1] && !due_q[0];
    wire [2:0] sel = {sel_pwr, sel_inex, sel_amb};
    wire push = q_in.valid && q_in.ready;
    wire [2:0] sent = push ? sel : 3'h0;

    wire [7:0] sel_ps = sel_inex ? `JEPC_PS_INEX : (sel_amb ? `JEPC_PS_AMB : `JEPC_PS_PWR);
    wire jepc_pkg::jepc_payload_t sel_pl = sel_inex ? inex_pl : (sel_amb ? amb_pl : pwr_pl);

    assign q_in.valid = |due_q;
    assign q_in.data = {make_id(TX_PRIO, sel_ps, src_addr), sel_pl};

    // A new period that lands on the send cycle keeps its flag
    always_ff @(posedge sys_clk or negedge rst_l) begin
        if (!rst_l) due_q <= 3'h0;
        else due_q <= expire | (due_q & ~sent);
    end

    // Back-pressure from the network stalls the scheduler via the FIFO
    jepc_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_l(rst_l),
        .wr(q_in),
        .rd(q_out)
    );

    // ----------------------------------------------------------------
    // Transmit output register
    // ----------------------------------------------------------------
    wire out_load = !tx_valid_q || tx_ready;
    assign q_out.ready = out_load;

    always_ff @(posedge sys_clk or negedge rst_l) begin
        if (!rst_l) begin
            tx_valid_q <= 1'b0;
            tx_id_q <= '0;
            tx_data_q <= '0;
        end else if (out_load) begin
            tx_valid_q <= q_out.valid;
            if (q_out.valid) begin
                tx_id_q <= q_out.data[FW-1 -: `JEPC_ID_W];
                tx_data_q <= q_out.data[`JEPC_PL_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive unpacking
    // ----------------------------------------------------------------
    wire jepc_pkg::jepc_grp_t rx_grp = grp_of(rx_id);
    wire rx_take = rx_valid && (rx_grp != jepc_pkg::JEPC_GRP_NONE);
    wire rx_amb = rx_valid && (rx_grp == jepc_pkg::JEPC_GRP_AMB);
    wire rx_inex = rx_valid && (rx_grp == jepc_pkg::JEPC_GRP_INEX);
    wire rx_pwr = rx_valid && (rx_grp == jepc_pkg::JEPC_GRP_PWR);

    always_ff @(posedge sys_clk or negedge rst_l) begin
        if (!rst_l) begin
            rx_hit_q <= 1'b0;
            rx_grp_q <= jepc_pkg::JEPC_GRP_NONE;
            rx_prio_q <= 3'h0;
            rx_src_q <= 8'h00;
        end else begin
            rx_hit_q <= rx_take;
            if (rx_take) begin
                rx_grp_q <= rx_grp;
                rx_prio_q <= rx_id[`JEPC_ID_W-1 -: 3];
                rx_src_q <= rx_id[`JEPC_ID_SA_LSB +: 8];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_l) begin
        if (!rst_l) begin
            rx_baro_press_q <= 8'h00;
            rx_cab_temp_q <= 16'h0000;
            rx_amb_temp_q <= 16'h0000;
            rx_inlet_temp_q <= 8'h00;
            rx_road_temp_q <= 16'h0000;
        end else if (rx_amb) begin
            rx_baro_press_q <= rx_data[`JEPC_BYTE1 +: 8];
            rx_cab_temp_q <= rx_data[`JEPC_BYTE2 +: 16];
            rx_amb_temp_q <= rx_data[`JEPC_BYTE4 +: 16];
            rx_inlet_temp_q <= rx_data[`JEPC_BYTE6 +: 8];
            rx_road_temp_q <= rx_data[`JEPC_BYTE7 +: 16];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_l) begin
        if (!rst_l) begin
            rx_trap_press_q <= 8'h00;
            rx_boost_press_q <= 8'h00;
            rx_manifold_temp_q <= 8'h00;
            rx_inlet_press_q <= 8'h00;
            rx_filter_dp_q <= 8'h00;
            rx_exhaust_temp_q <= 16'h0000;
            rx_coolant_dp_q <= 8'h00;
        end else if (rx_inex) begin
            rx_trap_press_q <= rx_data[`JEPC_BYTE1 +: 8];
            rx_boost_press_q <= rx_data[`JEPC_BYTE2 +: 8];
            rx_manifold_temp_q <= rx_data[`JEPC_BYTE3 +: 8];
            rx_inlet_press_q <= rx_data[`JEPC_BYTE4 +: 8];
            rx_filter_dp_q <= rx_data[`JEPC_BYTE5 +: 8];
            rx_exhaust_temp_q <= rx_data[`JEPC_BYTE6 +: 16];
            rx_coolant_dp_q <= rx_data[`JEPC_BYTE8 +: 8];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_l) begin
        if (!rst_l) begin
            rx_batt_current_q <= 8'h00;
            rx_alt_current_q <= 8'h00;
            rx_alt_volt_q <= 16'h0000;
            rx_elec_volt_q <= 16'h0000;
            rx_sw_batt_volt_q <= 16'h0000;
        end else if (rx_pwr) begin
            rx_batt_current_q <= rx_data[`JEPC_BYTE1 +: 8];
            rx_alt_current_q <= rx_data[`JEPC_BYTE2 +: 8];
            rx_alt_volt_q <= rx_data[`JEPC_BYTE3 +: 16];
            rx_elec_volt_q <= rx_data[`JEPC_BYTE5 +: 16];
            rx_sw_batt_volt_q <= rx_data[`JEPC_BYTE7 +: 16];
        end
    end
endmodule : jepc_host_codec
`default_nettype wire

// ===== test/jepc_net_model.sv
// Network-side model: takes sent frames and injects received ones
`default_nettype none
module jepc_net_model (
    input wire logic sys_clk,
    input wire logic stall,
    input wire logic tx_valid_q,
    input wire jepc_pkg::jepc_id_t tx_id_q,
    input wire jepc_pkg::jepc_payload_t tx_data_q,
    output logic tx_ready,
    output var logic rx_valid,
    output var jepc_pkg::jepc_id_t rx_id,
    output var jepc_pkg::jepc_payload_t rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    int n_frames = 0;
    jepc_pkg::jepc_id_t f_id [64];
    jepc_pkg::jepc_payload_t f_data [64];
    int f_cyc [64];
    // A stalled network leaves the frame standing at the codec
    assign tx_ready = !stall;
    initial begin
        rx_valid = 1'b0;
        rx_id = '0;
        rx_data = '0;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (tx_valid_q === 1'b1 && tx_ready && n_frames < 64) begin
            f_id[n_frames] <= tx_id_q;
            f_data[n_frames] <= tx_data_q;
            f_cyc[n_frames] <= cyc;
            n_frames <= n_frames + 1;
        end
    end
    task automatic put(input jepc_pkg::jepc_id_t id, input jepc_pkg::jepc_payload_t data);
        rx_valid = 1'b1;
        rx_id = id;
        rx_data = data;
    endtask : put
    // Released lines show the inverse, never a stale copy
    task automatic idle;
        rx_valid = 1'b0;
        rx_id = ~rx_id;
        rx_data = ~rx_data;
    endtask : idle
endmodule : jepc_net_model
`default_nettype wire

// ===== test/jepc_host_codec_assertions.sv
// Concurrent checks on the codec's frame ports
`default_nettype none
module jepc_host_codec_assertions #(parameter logic [2:0] TX_PRIO = 3'h6) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tx_valid_q,
    input wire logic tx_ready,
    input wire jepc_pkg::jepc_id_t tx_id_q,
    input wire jepc_pkg::jepc_payload_t tx_data_q,
    input wire logic rx_valid,
    input wire jepc_pkg::jepc_id_t rx_id,
    input wire jepc_pkg::jepc_payload_t rx_data,
    input wire logic rx_hit_q,
    input wire jepc_pkg::jepc_grp_t rx_grp_q,
    input wire logic [2:0] rx_prio_q,
    input wire logic [7:0] rx_src_q,
    input wire logic [7:0] rx_baro_press_q,
    input wire logic [15:0] rx_cab_temp_q,
    input wire logic [15:0] rx_road_temp_q,
    input wire logic [15:0] rx_exhaust_temp_q,
    input wire logic [7:0] rx_coolant_dp_q,
    input wire logic [7:0] rx_batt_current_q,
    input wire logic [15:0] rx_sw_batt_volt_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic rx_valid_d;
    jepc_pkg::jepc_id_t rx_id_d;
    jepc_pkg::jepc_payload_t rx_data_d;
    always_ff @(posedge sys_clk) begin
        rx_valid_d <= rx_valid;
        rx_id_d <= rx_id;
        rx_data_d <= rx_data;
    end
    sequence s_rx_grp(logic [7:0] ps);
        rx_valid && rx_id[25:16] == 10'h0fe && rx_id[15:8] == ps;
    endsequence
    sequence s_rx_foreign;
        rx_valid && (rx_id[25:16] != 10'h0fe || !(rx_id[15:8] inside {8'hf5, 8'hf6, 8'hf7}));
    endsequence
    a_tx_holds: assert property (tx_valid_q && !tx_ready |=> tx_valid_q &&
        $stable(tx_id_q) && $stable(tx_data_q)) else $error("frame changed while stalled");
    a_tx_id_fields: assert property (tx_valid_q |->
        tx_id_q[28:16] == {TX_PRIO, 2'h0, 8'hfe}) else $error("bad sent id fields");
    a_tx_group_code: assert property (tx_valid_q |->
        tx_id_q[15:8] inside {8'hf5, 8'hf6, 8'hf7}) else $error("bad sent group");
    a_amb_unpack: assert property (s_rx_grp(8'hf5) |=> rx_hit_q &&
        rx_grp_q == jepc_pkg::JEPC_GRP_AMB && {rx_road_temp_q, rx_cab_temp_q, rx_baro_press_q}
        == {rx_data_d[63:48], rx_data_d[23:0]}) else $error("ambient unpack wrong");
    a_inex_unpack: assert property (s_rx_grp(8'hf6) |=> rx_hit_q &&
        rx_grp_q == jepc_pkg::JEPC_GRP_INEX && rx_exhaust_temp_q == rx_data_d[55:40]
        && rx_coolant_dp_q == rx_data_d[63:56]) else $error("inlet unpack wrong");
    a_pwr_unpack: assert property (s_rx_grp(8'hf7) |=> rx_hit_q &&
        rx_grp_q == jepc_pkg::JEPC_GRP_PWR && rx_batt_current_q == rx_data_d[7:0]
        && rx_sw_batt_volt_q == rx_data_d[63:48]) else $error("power unpack wrong");
    a_rx_ignore: assert property (s_rx_foreign |=> !rx_hit_q &&
        $stable(rx_grp_q) && $stable(rx_cab_temp_q)) else $error("foreign frame taken");
    a_rx_origin: assert property (rx_hit_q |-> rx_valid_d &&
        {rx_prio_q, rx_src_q} == {rx_id_d[28:26], rx_id_d[7:0]}) else $error("bad origin");
endmodule : jepc_host_codec_assertions
bind jepc_host_codec jepc_host_codec_assertions #(.TX_PRIO(TX_PRIO)) u_chk (.sys_clk, .rst_n,
    .tx_valid_q, .tx_ready, .tx_id_q, .tx_data_q, .rx_valid, .rx_id, .rx_data, .rx_hit_q,
    .rx_grp_q, .rx_prio_q, .rx_src_q, .rx_baro_press_q, .rx_cab_temp_q, .rx_road_temp_q,
    .rx_exhaust_temp_q, .rx_coolant_dp_q, .rx_batt_current_q, .rx_sw_batt_volt_q);
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the environment and power group codec
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Short periods keep the run brief; ratios match the real rates
    localparam int P_AMB = 40;
    localparam int P_INEX = 20;
    localparam int P_PWR = 40;
    int n_mismatch = 0;
    int tests_run = 0;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic stall = 1'b0;
    // Over-range counts probe the clamps, the rest sit in range
    logic [7:0] src_addr = 8'h5a, baro_press = 8'hff, inlet_temp = 8'hfa, trap_press = 8'h01;
    logic [7:0] boost_press = 8'h7f, manifold_temp = 8'h00, inlet_press = 8'hfb, filter_dp = 8'h10;
    logic [7:0] coolant_dp = 8'h20, batt_current = 8'h7d, alt_current = 8'h00;
    logic [15:0] cab_temp = 16'hfc00, amb_temp = 16'hfb00, road_temp = 16'h1234;
    logic [15:0] exhaust_temp = 16'h2345, alt_volt = 16'hffff, elec_volt = 16'h0190;
    logic [15:0] sw_batt_volt = 16'hfaff;
    logic tx_valid_q, tx_ready, rx_valid, rx_hit_q;
    jepc_pkg::jepc_id_t tx_id_q, rx_id;
    jepc_pkg::jepc_payload_t tx_data_q, rx_data;
    jepc_pkg::jepc_grp_t rx_grp_q;
    logic [2:0] rx_prio_q;
    logic [7:0] rx_src_q, rx_baro_press_q, rx_inlet_temp_q, rx_trap_press_q, rx_boost_press_q;
    logic [7:0] rx_manifold_temp_q, rx_inlet_press_q, rx_filter_dp_q, rx_coolant_dp_q;
    logic [7:0] rx_batt_current_q, rx_alt_current_q;
    logic [15:0] rx_cab_temp_q, rx_amb_temp_q, rx_road_temp_q, rx_exhaust_temp_q;
    logic [15:0] rx_alt_volt_q, rx_elec_volt_q, rx_sw_batt_volt_q;

    jepc_host_codec #(.AMB_PERIOD_CYC(P_AMB), .INEX_PERIOD_CYC(P_INEX), .PWR_PERIOD_CYC(P_PWR))
    u_dut (.sys_clk, .rst_n, .src_addr, .baro_press, .cab_temp, .amb_temp, .inlet_temp,
        .road_temp, .trap_press, .boost_press, .manifold_temp, .inlet_press, .filter_dp,
        .exhaust_temp, .coolant_dp, .batt_current, .alt_current, .alt_volt, .elec_volt,
        .sw_batt_volt, .tx_valid_q, .tx_ready, .tx_id_q, .tx_data_q, .rx_valid, .rx_id,
        .rx_data, .rx_hit_q, .rx_grp_q, .rx_prio_q, .rx_src_q, .rx_baro_press_q,
        .rx_cab_temp_q, .rx_amb_temp_q, .rx_inlet_temp_q, .rx_road_temp_q, .rx_trap_press_q,
        .rx_boost_press_q, .rx_manifold_temp_q, .rx_inlet_press_q, .rx_filter_dp_q,
        .rx_exhaust_temp_q, .rx_coolant_dp_q, .rx_batt_current_q, .rx_alt_current_q,
        .rx_alt_volt_q, .rx_elec_volt_q, .rx_sw_batt_volt_q);
    jepc_net_model u_net (.sys_clk, .stall, .tx_valid_q, .tx_id_q, .tx_data_q, .tx_ready,
        .rx_valid, .rx_id, .rx_data);

    always #4 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] c8(input logic [7:0] v);
        return (v > 8'hfa) ? 8'hfa : v;
    endfunction : c8
    function automatic logic [15:0] c16(input logic [15:0] v, input logic [15:0] lim);
        return (v > lim) ? lim : v;
    endfunction : c16
    function automatic logic [63:0] exp_data(input logic [7:0] ps);
        case (ps)
            8'hf5: return {c16(road_temp, 16'hfb00), c8(inlet_temp), c16(amb_temp, 16'hfb00),
                c16(cab_temp, 16'hfb00), c8(baro_press)};
            8'hf6: return {c8(coolant_dp), c16(exhaust_temp, 16'hfb00), c8(filter_dp),
                c8(inlet_press), c8(manifold_temp), c8(boost_press), c8(trap_press)};
            default: return {c16(sw_batt_volt, 16'hfaff), c16(elec_volt, 16'hfaff),
                c16(alt_volt, 16'hfaff), c8(alt_current), c8(batt_current)};
        endcase
    endfunction : exp_data
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic wait_frames(input int n, input int lim);
        for (int i = 0; i < lim && u_net.n_frames < n; i++) begin
            @(negedge sys_clk);
        end
        if (u_net.n_frames < n) begin
            n_mismatch++;
            stop_test();
        end
    endtask : wait_frames

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_tx_groups;
        logic [7:0] order [8];
        order = '{8'hf6, 8'hf6, 8'hf5, 8'hf7, 8'hf6, 8'hf6, 8'hf5, 8'hf7};
        wait_frames(8, 400);
        for (int k = 0; k < 8; k++) begin
            check(u_net.f_id[k], {3'h6, 2'h0, 8'hfe, order[k], src_addr});
            check(u_net.f_data[k], exp_data(order[k]));
        end
        check(u_net.f_data[2], exp_data(8'hf5));
        check(u_net.f_data[0], exp_data(8'hf6));
        check(u_net.f_data[3], exp_data(8'hf7));
        check(64'(u_net.f_cyc[1] - u_net.f_cyc[0]), 64'(P_INEX));
        check(64'(u_net.f_cyc[6] - u_net.f_cyc[2]), 64'(P_AMB));
        check(64'(u_net.f_cyc[7] - u_net.f_cyc[3]), 64'(P_PWR));
    endtask : t_tx_groups

    task automatic t_stall;
        int n0;
        stall = 1'b1;
        repeat (150) @(negedge sys_clk);
        n0 = u_net.n_frames;
        check(tx_valid_q, 1'b1);
        stall = 1'b0;
        for (int k = 1; k <= 5; k++) begin
            @(negedge sys_clk);
            check(64'(u_net.n_frames - n0), 64'(k));
        end
        repeat (7) @(negedge sys_clk);
        // One held, four queued, three merged, three fresh from the next full period
        check(64'(u_net.n_frames - n0), 64'd11);
    endtask : t_stall

    task automatic t_rx;
        jepc_pkg::jepc_id_t ids [6];
        logic [63:0] dat [6];
        logic [1:0] grp [6];
        logic hit [6];
        ids = '{{3'h3, 2'h0, 8'hfe, 8'hf5, 8'h21}, {3'h6, 2'h0, 8'hfe, 8'hf6, 8'h30},
            {3'h7, 2'h0, 8'hfe, 8'hf7, 8'h42}, {3'h6, 2'h0, 8'hfe, 8'hf8, 8'h99},
            {3'h6, 2'h1, 8'hfe, 8'hf5, 8'h99}, {3'h6, 2'h0, 8'hfd, 8'hf6, 8'h99}};
        dat = '{64'h2710_40_2a00_2500_64, 64'h11_3000_22_33_44_55_66,
            64'h0111_0222_0333_7d_7e, 64'h0123_4567_89ab_cdef, 64'h0123_4567_89ab_cdef,
            64'h0123_4567_89ab_cdef};
        grp = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
        hit = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        for (int k = 0; k < 6; k++) begin
            u_net.put(ids[k], dat[k]);
            @(negedge sys_clk);
            check(rx_hit_q, hit[k]);
            check(rx_grp_q, grp[k]);
        end
        u_net.idle();
        check({rx_road_temp_q, rx_inlet_temp_q, rx_amb_temp_q, rx_cab_temp_q,
            rx_baro_press_q}, dat[0]);
        check({rx_coolant_dp_q, rx_exhaust_temp_q, rx_filter_dp_q, rx_inlet_press_q,
            rx_manifold_temp_q, rx_boost_press_q, rx_trap_press_q}, dat[1]);
        check({rx_sw_batt_volt_q, rx_elec_volt_q, rx_alt_volt_q, rx_alt_current_q,
            rx_batt_current_q}, dat[2]);
        check({rx_prio_q, rx_src_q}, {3'h7, 8'h42});
    endtask : t_rx

    task automatic t_reset;
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        check({tx_valid_q, rx_hit_q, rx_grp_q, rx_cab_temp_q, tx_id_q}, 64'h0);
        u_net.n_frames = 0;
        rst_n = 1'b1;
        wait_frames(1, P_INEX + 20);
        check(u_net.f_id[0][15:8], 8'hf6);
        check(u_net.f_data[0], exp_data(8'hf6));
    endtask : t_reset

    initial begin
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        t_tx_groups();
        t_stall();
        t_rx();
        t_reset();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
